/* File: edge_sync.v */
// Two-flop synchroniser with rising edge detection for pin inputs.
// Assumes the input comes from a foreign domain; nothing else reads stage one.
`timescale 1ns/100ps
module edge_sync #(
  parameter W = 1
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire [W-1:0] pin_in,
  output wire [W-1:0] level,
  output wire [W-1:0] rise
);
  reg [W-1:0] stage1_ff;
  reg [W-1:0] stage2_ff;
  reg [W-1:0] stage3_ff;

  // Stage one feeds only stage two; stage three keeps the old level for edges
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stage1_ff <= {W{1'b0}};
      stage2_ff <= {W{1'b0}};
      stage3_ff <= {W{1'b0}};
    end else begin
      stage1_ff <= pin_in;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
    end
  end

  assign level = stage2_ff;
  assign rise = stage2_ff & ~stage3_ff;
endmodule

/* File: link_peer.sv */
// Far-side model: word source for capture, word sink for generation.
// Assumes the bench switches the source and the sink's busy level.
`timescale 1ns/100ps
module link_peer (
  input wire src_on,
  input wire busy,
  input wire dst_clk,
  input wire dst_valid,
  input wire [31:0] dst_data,
  output reg link_clk_in = 1'b0,
  output reg link_valid_in = 1'b0,
  output reg [31:0] link_data_in = 32'h0,
  output wire link_hold_in,
  output reg [31:0] n_words = 32'h0
);
  reg [31:0] seen [0:15];
  reg [1:0] ph = 2'h0;
  reg [31:0] seq = 32'h0000_a000;
  // Free-running 80 ns link clock, phase unrelated to clk_sys
  initial begin
    #13;
    forever #40 link_clk_in = ~link_clk_in;
  end
  // Words change at falling edge; every fourth slot idle with inverted data
  always @(negedge link_clk_in) begin
    ph <= ph + 2'h1;
    link_valid_in <= src_on && ph != 2'h3;
    if (src_on && ph != 2'h3) begin
      link_data_in <= seq;
      seq <= seq + 32'h1;
    end else begin
      link_data_in <= ~link_data_in;
    end
    if (!src_on) seq <= 32'h0000_a000;
  end
  // Sink says it is full through busy
  assign link_hold_in = busy;
  // Sink samples mid-period, at the rising edge
  always @(posedge dst_clk) begin
    if (dst_valid) begin
      seen[n_words[3:0]] <= dst_data;
      n_words <= n_words + 32'h1;
    end
  end
endmodule

/* File: lvds_io_consts.vh */
// Constants for the parallel word port: register offsets, field positions,
// reset values and timing counts. Included by the port design and its test bench.
`ifndef LVDS_IO_CONSTS_VH
`define LVDS_IO_CONSTS_VH

`define WORD_W 32
`define ADDR_W 8

// Register offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_HOLD_LVL 8'h08
`define REG_FIFO_DATA 8'h0c
`define REG_FILL 8'h10
`define REG_LIST_IDX 8'h14
`define REG_LIST_LEN 8'h18
`define REG_LIST_DLY 8'h1c
`define REG_LIST_REP 8'h20
`define REG_LIST_CNT 8'h24
`define REG_TABLE_ADR 8'h28
`define REG_TABLE_DAT 8'h2c
`define REG_TRIGGER 8'h30

// Control fields
`define CTRL_RUN 0
`define CTRL_TEST_SRC 1
`define CTRL_CAPTURE 2
`define CTRL_HOLD_OUT_EN 3
`define CTRL_HOLD_IN_EN 4
`define CTRL_RESET 32'h0000_0000

// Buffer and list sizes
`define BUF_AW 9
`define BUF_DEPTH 512
`define LIST_AW 6
`define LIST_DEPTH 64
`define TBL_AW 10
`define TBL_DEPTH 1024
`define HOLD_LVL_RESET 9'h1f0

// Start delay unit: 1 us per count at 4 ns clock
`define DLY_UNIT_NS 1000
`define CLK_NS 4
`define DLY_UNIT_CYC (`DLY_UNIT_NS / `CLK_NS)

`endif

/* File: lvds_word_port.v */
// Parallel word port: capture path into a buffer and generation path from
// tables run by a list sequencer. Assumes a 250 MHz clk_sys, link pins from
// outside the domain, and link rates well below a quarter of clk_sys.
//
// How it works
// [R1] Input strap selects receive, source clocks link
// [R2] Word taken on clock edge when qualifier high
// [R3] Source keeps clock running, marks valid words
// [R4] Hold output asserted when input cannot continue
// [R5] Receive word from pins or test pattern
// [R6] Own buffer, FIFO or transient capture mode
// [R7] Output strap: device drives clock, qualifier
// [R8] Outgoing clock free-running; qualifier marks valid words
// [R9] Hold input stops new words when enabled
// [R10] Destination raises hold when full, releases later
// [R11] Sequencer sends 32-bit words from tables
// [R12] Entry: length, start delay, repeat count; the code applies only entry 0's start delay
// [R13] Up to 64 entries chained in order
// [R14] Held output: qualifier low, position kept
// [R15] Hold output raised before buffer overflows
`timescale 1ns/100ps
`include "lvds_io_consts.vh"
module lvds_word_port (
  input wire clk_sys,
  input wire sys_rst,
  input wire strap_output_mode,
  input wire link_clk_in,
  input wire link_valid_in,
  input wire [31:0] link_data_in,
  input wire link_hold_in,
  output reg link_clk_out,
  output reg link_valid_out,
  output reg [31:0] link_data_out,
  output wire link_clk_oe,
  output wire link_data_oe,
  output reg link_hold_out,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata
);
  localparam S_IDLE = 3'd0;
  localparam S_DELAY = 3'd1;
  localparam S_SEND = 3'd2;
  localparam S_NEXT = 3'd3;
  localparam S_DONE = 3'd4;
  localparam [7:0] CLK_HALF = 8'd4;

  reg [31:0] ctrl_ff;
  reg [8:0] hold_lvl_ff;
  reg strap_ff;
  reg strap_ok_ff;
  wire [2:0] pin_lvl;
  wire [2:0] pin_rise;
  reg [31:0] data_s1_ff;
  reg [31:0] data_s2_ff;
  reg [31:0] test_ff;
  reg [31:0] buf_mem [0:`BUF_DEPTH-1];
  reg [`BUF_AW:0] wptr_ff;
  reg [`BUF_AW:0] rptr_ff;
  reg overflow_ff;
  reg capture_done_ff;
  reg [15:0] list_len [0:`LIST_DEPTH-1];
  reg [15:0] list_base [0:`LIST_DEPTH-1];
  reg [23:0] list_dly [0:`LIST_DEPTH-1];
  reg [15:0] list_rep [0:`LIST_DEPTH-1];
  reg [31:0] tbl_mem [0:`TBL_DEPTH-1];
  reg [5:0] list_idx_ff;
  reg [6:0] list_cnt_ff;
  reg [9:0] tbl_adr_ff;
  reg [2:0] state_ff;
  reg [5:0] ent_ff;
  reg [15:0] pos_ff;
  reg [15:0] rep_ff;
  reg [23:0] dly_ff;
  reg [7:0] unit_ff;
  reg [7:0] div_ff;
  reg trig_ff;
  wire [`BUF_AW:0] fill;
  wire buf_full;
  wire rx_mode;
  wire tx_mode;
  wire run;
  wire take;
  wire [31:0] rx_word;
  wire tx_fall;
  wire held;
  wire pop;

  // Decode a register offset; used by both strobe paths
  function hit;
    input [7:0] a;
    input [7:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  // Strap is caught after reset release, not by the reset itself
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      strap_ff <= 1'b0;
      strap_ok_ff <= 1'b0;
    end else if (!strap_ok_ff) begin
      strap_ff <= strap_output_mode;
      strap_ok_ff <= 1'b1;
    end
  end

  assign rx_mode = strap_ok_ff & ~strap_ff; // [R1]
  assign tx_mode = strap_ok_ff & strap_ff; // [R7]
  assign run = ctrl_ff[`CTRL_RUN];
  assign link_clk_oe = tx_mode; // [R7]
  assign link_data_oe = tx_mode;

  // Link clock, qualifier and hold pass two flops before any logic
  edge_sync #(
    .W(3)
  ) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_in({link_hold_in, link_valid_in, link_clk_in}),
    .level(pin_lvl),
    .rise(pin_rise)
  );

  // Data lines delayed to line up with the synchronised clock edge
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      data_s1_ff <= 32'h0000_0000;
      data_s2_ff <= 32'h0000_0000;
    end else begin
      data_s1_ff <= link_data_in;
      data_s2_ff <= data_s1_ff;
    end
  end

  assign fill = wptr_ff - rptr_ff;
  assign buf_full = (fill == `BUF_DEPTH);
  // Words taken only on a link clock edge with qualifier high
  assign take = rx_mode & run & pin_rise[0] & pin_lvl[1] & ~capture_done_ff; // [R2] [R3]
  assign rx_word = ctrl_ff[`CTRL_TEST_SRC] ? test_ff : data_s2_ff; // [R5]
  assign pop = reg_rd & hit(reg_addr, `REG_FIFO_DATA) & (fill != {(`BUF_AW+1){1'b0}});

  // Test pattern advances per taken word so gaps are visible in the data
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      test_ff <= 32'h0000_0000;
    end else if (take && ctrl_ff[`CTRL_TEST_SRC]) begin
      test_ff <= test_ff + 32'h0000_0001; // [R5]
    end
  end

  // Buffer write side; FIFO wraps on read, capture stops when block is full
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wptr_ff <= {(`BUF_AW+1){1'b0}};
      overflow_ff <= 1'b0;
      capture_done_ff <= 1'b0;
    end else if (reg_wr && hit(reg_addr, `REG_CTRL)) begin
      wptr_ff <= {(`BUF_AW+1){1'b0}};
      overflow_ff <= take & buf_full; // A word dropped for a full buffer in the clear cycle still counts
      capture_done_ff <= 1'b0;
    end else if (take) begin
      if (buf_full) begin
        overflow_ff <= 1'b1;
      end else begin
        wptr_ff <= wptr_ff + 1'b1; // [R6]
        if (ctrl_ff[`CTRL_CAPTURE] && fill == `BUF_DEPTH - 1) begin
          capture_done_ff <= 1'b1; // [R6]
        end
      end
    end
  end

  always @(posedge clk_sys) begin
    if (take && !buf_full) begin
      buf_mem[wptr_ff[`BUF_AW-1:0]] <= rx_word;
    end
  end

  // Read side: software drains one word per read of the data register
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rptr_ff <= {(`BUF_AW+1){1'b0}};
    end else if (reg_wr && hit(reg_addr, `REG_CTRL)) begin
      rptr_ff <= {(`BUF_AW+1){1'b0}};
    end else if (pop) begin
      rptr_ff <= rptr_ff + 1'b1;
    end
  end

  // Hold output raised at a margin below full, covering pin latency
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      link_hold_out <= 1'b0;
    end else begin
      link_hold_out <= rx_mode & ctrl_ff[`CTRL_HOLD_OUT_EN] &
        ((fill >= {1'b0, hold_lvl_ff}) | capture_done_ff | ~run); // [R4] [R15]
    end
  end

  // Outgoing clock divided from clk_sys; runs freely whenever in output mode
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      div_ff <= 8'h00;
      link_clk_out <= 1'b0;
    end else if (tx_mode) begin
      if (div_ff == CLK_HALF - 8'd1) begin
        div_ff <= 8'h00;
        link_clk_out <= ~link_clk_out; // [R8]
      end else begin
        div_ff <= div_ff + 8'h01;
      end
    end
  end

  // New words launched on the falling edge so the destination samples on rising
  assign tx_fall = tx_mode & link_clk_out & (div_ff == CLK_HALF - 8'd1);
  assign held = ctrl_ff[`CTRL_HOLD_IN_EN] & pin_lvl[2]; // [R9] [R10]

  // Linked-list sequencer: delay (first entry only), then length words, repeated, then next entry
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= S_IDLE;
      ent_ff <= 6'h00;
      pos_ff <= 16'h0000;
      rep_ff <= 16'h0000;
      dly_ff <= 24'h000000;
      unit_ff <= 8'h00;
      link_valid_out <= 1'b0;
      link_data_out <= 32'h0000_0000;
    end else if (!run || !tx_mode) begin
      state_ff <= S_IDLE;
      link_valid_out <= 1'b0;
    end else begin
      case (state_ff)
        S_IDLE: begin
          link_valid_out <= 1'b0;
          if (trig_ff && list_cnt_ff != 7'h00) begin
            ent_ff <= 6'h00;
            dly_ff <= list_dly[0];
            unit_ff <= 8'h00;
            pos_ff <= 16'h0000;
            rep_ff <= 16'h0000;
            state_ff <= S_DELAY; // [R12]
          end
        end
        S_DELAY: begin
          if (dly_ff == 24'h000000) begin
            state_ff <= S_SEND;
          end else if (unit_ff == `DLY_UNIT_CYC - 1) begin
            unit_ff <= 8'h00;
            dly_ff <= dly_ff - 24'h000001; // [R12]
          end else begin
            unit_ff <= unit_ff + 8'h01;
          end
        end
        S_SEND: begin
          if (tx_fall) begin
            if (held) begin
              link_valid_out <= 1'b0; // [R14]
            end else begin
              link_data_out <= tbl_mem[list_base[ent_ff][9:0] + pos_ff[9:0]]; // [R11]
              link_valid_out <= 1'b1; // [R8]
              if (pos_ff == list_len[ent_ff] - 16'h0001) begin
                pos_ff <= 16'h0000;
                if (rep_ff == list_rep[ent_ff]) begin
                  state_ff <= S_NEXT;
                end else begin
                  rep_ff <= rep_ff + 16'h0001; // [R12]
                end
              end else begin
                pos_ff <= pos_ff + 16'h0001; // [R14]
              end
            end
          end
        end
        S_NEXT: begin
          if (tx_fall) begin
            link_valid_out <= 1'b0;
            if ({1'b0, ent_ff} == list_cnt_ff - 7'h01) begin
              state_ff <= S_DONE;
            end else begin
              ent_ff <= ent_ff + 6'h01; // [R13]
              dly_ff <= 24'h000000;
              rep_ff <= 16'h0000;
              state_ff <= S_SEND; // [R13]
            end
          end
        end
        S_DONE: begin
          link_valid_out <= 1'b0;
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // Registers written by software; trigger is a one-cycle pulse
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff <= `CTRL_RESET;
      hold_lvl_ff <= `HOLD_LVL_RESET;
      list_idx_ff <= 6'h00;
      list_cnt_ff <= 7'h00;
      tbl_adr_ff <= 10'h000;
      trig_ff <= 1'b0;
    end else begin
      trig_ff <= reg_wr & hit(reg_addr, `REG_TRIGGER);
      if (reg_wr) begin
        case (reg_addr)
          `REG_CTRL: ctrl_ff <= {27'h0000000, reg_wdata[4:0]};
          `REG_HOLD_LVL: hold_lvl_ff <= reg_wdata[8:0];
          `REG_LIST_IDX: list_idx_ff <= reg_wdata[5:0];
          `REG_LIST_CNT: list_cnt_ff <= (reg_wdata[6:0] > 7'd64) ? 7'd64 : reg_wdata[6:0]; // [R13]
          `REG_TABLE_ADR: tbl_adr_ff <= reg_wdata[9:0];
          `REG_TABLE_DAT: tbl_adr_ff <= tbl_adr_ff + 10'h001;
          default: begin
          end
        endcase
      end
    end
  end

  // List entries and table words live in local arrays, no reset needed
  always @(posedge clk_sys) begin
    if (reg_wr && hit(reg_addr, `REG_LIST_LEN)) begin
      list_len[list_idx_ff] <= reg_wdata[15:0];
      list_base[list_idx_ff] <= reg_wdata[31:16];
    end
    if (reg_wr && hit(reg_addr, `REG_LIST_DLY)) begin
      list_dly[list_idx_ff] <= reg_wdata[23:0];
    end
    if (reg_wr && hit(reg_addr, `REG_LIST_REP)) begin
      list_rep[list_idx_ff] <= reg_wdata[15:0];
    end
    if (reg_wr && hit(reg_addr, `REG_TABLE_DAT)) begin
      tbl_mem[tbl_adr_ff] <= reg_wdata;
    end
  end

  // Read data one cycle after the strobe; unmapped offsets read zero
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL: reg_rdata <= ctrl_ff;
        `REG_STATUS: reg_rdata <= {24'h000000, state_ff, link_hold_out, overflow_ff,
          capture_done_ff, tx_mode, rx_mode};
        `REG_HOLD_LVL: reg_rdata <= {23'h000000, hold_lvl_ff};
        `REG_FIFO_DATA: reg_rdata <= buf_mem[rptr_ff[`BUF_AW-1:0]]; // Head word, fresh on back-to-back pops
        `REG_FILL: reg_rdata <= {22'h000000, fill};
        `REG_LIST_IDX: reg_rdata <= {26'h0000000, list_idx_ff};
        `REG_LIST_CNT: reg_rdata <= {25'h0000000, list_cnt_ff};
        `REG_TABLE_ADR: reg_rdata <= {22'h000000, tbl_adr_ff};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule

/* File: lvds_word_port_sva.sv */
// Checker for the word port, seeing only the top ports.
// Assumes one clk_sys domain and sys_rst asynchronous, active high.
`timescale 1ns/100ps
module lvds_word_port_sva (
  input wire clk_sys,
  input wire sys_rst,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire link_clk_out,
  input wire link_valid_out,
  input wire [31:0] link_data_out,
  input wire link_clk_oe,
  input wire link_data_oe,
  input wire link_hold_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Generated clock halves, four clk_sys cycles each
  sequence s_high;
    link_clk_out [*4];
  endsequence
  sequence s_low;
    !link_clk_out [*4];
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its answer cycle");
  a_oe_pair: assert property (link_clk_oe == link_data_oe)
    else $error("clock and data enables differ");
  a_valid_needs_oe: assert property (link_valid_out |-> link_clk_oe)
    else $error("qualifier high while not driving");
  a_mode_kept: assert property ($past(link_clk_oe) |-> link_clk_oe)
    else $error("output mode dropped without reset");
  a_hold_rx_only: assert property (link_hold_out |-> !link_clk_oe)
    else $error("hold output raised in output mode");
  a_clk_period: assert property ($rose(link_clk_out) |-> s_high ##1 s_low ##1 link_clk_out)
    else $error("generated clock period wrong");
  a_valid_at_fall: assert property ($changed(link_valid_out) |-> $fell(link_clk_out))
    else $error("qualifier moved off the falling edge");
  a_data_held: assert property (link_valid_out && !$fell(link_clk_out) |-> $stable(link_data_out))
    else $error("word changed inside its period");
endmodule
bind lvds_word_port lvds_word_port_sva chk (
  .clk_sys(clk_sys),
  .sys_rst(sys_rst),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .link_clk_out(link_clk_out),
  .link_valid_out(link_valid_out),
  .link_data_out(link_data_out),
  .link_clk_oe(link_clk_oe),
  .link_data_oe(link_data_oe),
  .link_hold_out(link_hold_out)
);

/* File: lvds_word_port_test.sv */
// Self-checking bench for the word port: register tasks plus a link peer.
// Assumes a 4 ns clk_sys; the strap is set per reset.
`timescale 1ns/100ps
`include "lvds_io_consts.vh"
module lvds_word_port_test;
  reg clk_sys = 1'b0;
  reg sys_rst = 1'b1;
  reg strap = 1'b0;
  reg src_on = 1'b0;
  reg busy = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  wire [31:0] reg_rdata, link_data_in, link_data_out, n_words;
  wire link_clk_in, link_valid_in, link_hold_in, link_clk_out, link_valid_out;
  wire link_clk_oe, link_data_oe, link_hold_out;
  integer errors = 0;
  integer n_checks = 0;
  integer i;
  reg [31:0] d, d2;
  lvds_word_port dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .strap_output_mode(strap),
    .link_clk_in(link_clk_in), .link_valid_in(link_valid_in), .link_data_in(link_data_in),
    .link_hold_in(link_hold_in), .link_clk_out(link_clk_out), .link_valid_out(link_valid_out),
    .link_data_out(link_data_out), .link_clk_oe(link_clk_oe), .link_data_oe(link_data_oe),
    .link_hold_out(link_hold_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  link_peer peer (.src_on(src_on), .busy(busy), .dst_clk(link_clk_out), .dst_valid(link_valid_out),
    .dst_data(link_data_out), .link_clk_in(link_clk_in), .link_valid_in(link_valid_in),
    .link_data_in(link_data_in), .link_hold_in(link_hold_in), .n_words(n_words));
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task report_and_stop;
    begin
      $display("Checks %0d, mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Strobe then idle cycle, so no strobe is assigned twice in one step
  task wr(input [7:0] a, input [31:0] v);
    begin
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task rd(input [7:0] a, output [31:0] v);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      @(posedge clk_sys);
    end
  endtask
  // Two reads with no gap: the strobe stays up across both edges
  task rd_pair(input [7:0] a, output [31:0] v0, output [31:0] v1);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      #1 v0 = reg_rdata;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v1 = reg_rdata;
      @(posedge clk_sys);
    end
  endtask
  // Bounded poll until any masked bit is set
  task poll(input [7:0] a, input [31:0] m);
    integer k;
    begin
      d = 32'h0;
      for (k = 0; k < 20000 && (d & m) == 32'h0; k = k + 1) rd(a, d);
      if ((d & m) == 32'h0) begin
        chk(d, m);
        report_and_stop;
      end
    end
  endtask
  task wait_words(input [31:0] n);
    integer k;
    begin
      for (k = 0; k < 3000 && n_words < n; k = k + 1) @(posedge clk_sys);
      chk(n_words, n);
      if (n_words < n) report_and_stop;
    end
  endtask
  task reset_dut(input s);
    begin
      sys_rst <= 1'b1;
      strap <= s;
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask
  initial begin
    @(posedge clk_sys);
    reset_dut(1'b0);
    rd(`REG_STATUS, d);
    chk(d, 32'h1);
    chk({30'h0, link_clk_oe, link_data_oe}, 32'h0);
    rd(`REG_CTRL, d);
    chk(d, `CTRL_RESET);
    rd(`REG_HOLD_LVL, d);
    chk(d, {23'h0, `HOLD_LVL_RESET});
    rd(8'hfc, d);
    chk(d, 32'h0);
    $display("test reset done");
    // Test pattern counts from zero per taken word
    wr(`REG_CTRL, 32'h3);
    src_on <= 1'b1;
    poll(`REG_FILL, 32'h3fc);
    src_on <= 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      rd(`REG_FIFO_DATA, d);
      chk(d, i);
    end
    $display("test pattern done");
    // Idle slots carry junk, so any extra word shows as a wrong value
    wr(`REG_CTRL, 32'h1);
    src_on <= 1'b1;
    poll(`REG_FILL, 32'h3fc);
    src_on <= 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      rd(`REG_FIFO_DATA, d);
      chk(d, 32'h0000_a000 + i);
    end
    $display("test capture fifo done");
    wr(`REG_HOLD_LVL, 32'h4);
    wr(`REG_CTRL, 32'h9);
    src_on <= 1'b1;
    poll(`REG_STATUS, 32'h10);
    src_on <= 1'b0;
    chk({31'h0, link_hold_out}, 32'h1);
    rd(`REG_FILL, d);
    chk({31'h0, d >= 32'h4 && d <= 32'h6}, 32'h1);
    rd(`REG_STATUS, d);
    chk(d & 32'h8, 32'h0);
    $display("test hold out done");
    wr(`REG_CTRL, 32'h5);
    src_on <= 1'b1;
    poll(`REG_STATUS, 32'h4);
    src_on <= 1'b0;
    rd(`REG_FILL, d);
    chk(d, `BUF_DEPTH);
    rd(`REG_STATUS, d);
    chk(d & 32'h8, 32'h0);
    rd_pair(`REG_FIFO_DATA, d, d2);
    chk(d, 32'h0000_a000);
    chk(d2, 32'h0000_a001);
    $display("test transient done");
    reset_dut(1'b1);
    rd(`REG_STATUS, d);
    chk(d, 32'h2);
    chk({30'h0, link_clk_oe, link_data_oe}, 32'h3);
    wr(`REG_LIST_CNT, 32'h41);
    rd(`REG_LIST_CNT, d);
    chk(d, `LIST_DEPTH);
    wr(`REG_TABLE_ADR, 32'h0);
    for (i = 0; i < 3; i = i + 1) wr(`REG_TABLE_DAT, 32'hc000_0000 + i);
    // Entry 0: three words twice after one delay unit; entry 1: words 1..2 once
    wr(`REG_LIST_IDX, 32'h0);
    wr(`REG_LIST_LEN, 32'h0000_0003);
    wr(`REG_LIST_DLY, 32'h1);
    wr(`REG_LIST_REP, 32'h1);
    wr(`REG_LIST_IDX, 32'h1);
    wr(`REG_LIST_LEN, 32'h0001_0002);
    wr(`REG_LIST_DLY, 32'h0);
    wr(`REG_LIST_REP, 32'h0);
    wr(`REG_LIST_CNT, 32'h2);
    wr(`REG_CTRL, 32'h11);
    wr(`REG_TRIGGER, 32'h0);
    repeat (200) @(posedge clk_sys);
    chk(n_words, 32'h0);
    wait_words(32'h2);
    busy <= 1'b1;
    repeat (30) @(posedge clk_sys);
    d = n_words;
    repeat (100) @(posedge clk_sys);
    chk(n_words, d);
    busy <= 1'b0;
    wait_words(32'h8);
    repeat (50) @(posedge clk_sys);
    chk(n_words, 32'h8);
    for (i = 0; i < 8; i = i + 1) chk(peer.seen[i], 32'hc000_0000 + (i < 6 ? i % 3 : i - 5));
    rd(`REG_STATUS, d);
    chk(d, 32'h82);
    $display("test generation done");
    report_and_stop;
  end
endmodule
